// ==== include/ubf_pkg.sv ====
`default_nettype none
package ubf_pkg;
  // Register indices; byte address on the bus is four times the index
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_TRIM_HI = 8'h84;
  localparam logic [7:0] IDX_TRIM_LO = 8'h85;
  localparam logic [7:0] IDX_PWR_CTRL = 8'h87;
  localparam logic [7:0] IDX_SER_CTRL = 8'h98;
  localparam logic [7:0] IDX_T3_CTRL = 8'hC4;
  localparam logic [7:0] IDX_RLD_LO = 8'hC5;
  localparam logic [7:0] IDX_RLD_HI = 8'hC6;
  localparam logic [7:0] T3_CTRL_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Field positions
  localparam int T3C_P1_DBL = 7;
  localparam int T3C_SRC_SEL = 5;
  localparam int SC_TOP = 7;
  localparam int SC_SM1 = 6;
  localparam int SC_FAST_MP = 5;
  localparam int SC_REN = 4;
  localparam int PC_DBL = 7;
  localparam int PC_FEA = 6;
  // Rate dividers of the system-clock modes
  localparam int M0_DIV_SLOW = 12;
  localparam int M0_DIV_FAST = 2;
  localparam int OVS = 16;
  localparam int M2_DIV_SLOW = 64 / OVS;
  localparam int M2_DIV_FAST = 32 / OVS;
  localparam logic [3:0] M0_LIM_SLOW = 4'(M0_DIV_SLOW - 1);
  localparam logic [3:0] M0_LIM_FAST = 4'(M0_DIV_FAST - 1);
  localparam logic [3:0] M2_LIM_SLOW = 4'(M2_DIV_SLOW - 1);
  localparam logic [3:0] M2_LIM_FAST = 4'(M2_DIV_FAST - 1);
  localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  localparam logic [3:0] BITS_M1 = 4'h8;
  localparam logic [3:0] BITS_M23 = 4'h9;
  localparam int WORD_W = 9;
  typedef enum logic [1:0] {UBF_MODE0, UBF_MODE1, UBF_MODE2, UBF_MODE3} ubf_mode_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_SHIFT, RX_STOP, RX_PUSH} ubf_rx_state_t;
endpackage
`default_nettype wire

// ==== include/ubf_stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ubf_stream_if #(parameter int WIDTH = 9) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== rtl/ubf_buffer.sv ====
`timescale 1ns/1ps
`default_nettype none
module ubf_buffer (
  input wire logic aclk,
  input wire logic aresetn,
  ubf_stream_if.snk in_s,
  ubf_stream_if.src out_s
);
  logic [1:0] cnt_q;
  logic [$bits(in_s.data)-1:0] d0_q;
  logic [$bits(in_s.data)-1:0] d1_q;
  wire push = in_s.valid && in_s.ready;
  wire pop = out_s.valid && out_s.ready;
  // Slot 0 always holds the oldest word, so the output comes straight from a flop
  wire wr0 = push && (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop));
  wire wr1 = push && !wr0;
  assign in_s.ready = cnt_q != 2'h2;
  assign out_s.valid = cnt_q != 2'h0;
  assign out_s.data = d0_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge aclk) begin
    if (wr0) begin
      d0_q <= in_s.data;
    end else if (pop) begin
      d0_q <= d1_q;
    end
    if (wr1) begin
      d1_q <= in_s.data;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/ubf_top.sv ====
// Overview of operation
// - Source bit picks Timer1 or Timer3 overflows
// - Timer1 source: doubled/32 of overflow rate
// - Timer3: port0 doubled/32, port1 one sixteenth
// - Timer3 reload is high*256 plus low
// - Nine-bit trim split high byte, low bit
// - Trim resets to nominal, writes act immediately
// - Bad stop bit sets framing error
// - Top control bit shows error or mode
// - Error flag sticky until software clears
// - Stop bit judged at its midpoint
// - Port1 baud always from Timer3
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ubf_top
  import ubf_pkg::*;
#(
  parameter logic [8:0] TRIM_RESET = 9'h100
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer1_overflow,
  input wire logic timer3_overflow,
  input wire logic rx0_pin,
  output logic port0_sample_tick,
  output logic port0_bit_tick,
  output logic port1_bit_tick,
  output logic [8:0] oscillator_trim_value,
  output logic [15:0] timer3_reload_value,
  output logic [7:0] timer3_uart_control,
  output logic [WORD_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);
  // Register storage
  logic [7:0] osc_trim_high_q;
  logic osc_trim_low_bit_q;
  logic [7:0] t3_ctrl_q;
  logic [7:0] timer3_reload_low_q;
  logic [7:0] timer3_reload_high_q;
  logic port0_baud_double_q;
  logic error_flag_access_select_q;
  logic mode_select_high_bit_q;
  logic mode_low_bit_q;
  logic fast_mode0_or_multiproc_bit_q;
  logic receive_enable_q;
  logic framing_error_flag_q;
  logic framing_error_flag_d;

  // Bus slave state
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] aw_idx_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Write side: address and data are taken independently, then applied together
  wire reg_wr = aw_hold_q && w_hold_q && !bvalid_q;
  wire wen = reg_wr && w_strb_q;
  wire wr_trim_hi = wen && aw_idx_q == IDX_TRIM_HI;
  wire wr_trim_lo = wen && aw_idx_q == IDX_TRIM_LO;
  wire wr_pwr_ctrl = wen && aw_idx_q == IDX_PWR_CTRL;
  wire wr_ser_ctrl = wen && aw_idx_q == IDX_SER_CTRL;
  wire wr_t3_ctrl = wen && aw_idx_q == IDX_T3_CTRL;
  wire wr_reload_lo = wen && aw_idx_q == IDX_RLD_LO;
  wire wr_reload_hi = wen && aw_idx_q == IDX_RLD_HI;
  wire wr_hit = aw_idx_q inside {IDX_TRIM_HI, IDX_TRIM_LO, IDX_PWR_CTRL, IDX_SER_CTRL, IDX_T3_CTRL,
                                 IDX_RLD_LO, IDX_RLD_HI};
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_idx_q <= 8'h00;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
      if (reg_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read side
  wire [7:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
  wire ser_top = error_flag_access_select_q ? framing_error_flag_q : mode_select_high_bit_q;
  wire [7:0] ser_rd = {ser_top, mode_low_bit_q, fast_mode0_or_multiproc_bit_q, receive_enable_q, 4'h0};
  wire [7:0] pwr_rd = {port0_baud_double_q, error_flag_access_select_q, 6'h00};
  wire rd_hit = rd_idx inside {IDX_TRIM_HI, IDX_TRIM_LO, IDX_PWR_CTRL, IDX_SER_CTRL, IDX_T3_CTRL,
                               IDX_RLD_LO, IDX_RLD_HI};
  wire [7:0] rd_byte = rd_idx == IDX_TRIM_HI ? osc_trim_high_q :
                       rd_idx == IDX_TRIM_LO ? {7'h00, osc_trim_low_bit_q} :
                       rd_idx == IDX_PWR_CTRL ? pwr_rd :
                       rd_idx == IDX_SER_CTRL ? ser_rd :
                       rd_idx == IDX_T3_CTRL ? t3_ctrl_q :
                       rd_idx == IDX_RLD_LO ? timer3_reload_low_q :
                       rd_idx == IDX_RLD_HI ? timer3_reload_high_q : 8'h00;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_trim_high_q <= TRIM_RESET[8:1];
      osc_trim_low_bit_q <= TRIM_RESET[0];
      t3_ctrl_q <= T3_CTRL_RESET;
      timer3_reload_low_q <= 8'h00;
      timer3_reload_high_q <= 8'h00;
      port0_baud_double_q <= 1'b0;
      error_flag_access_select_q <= 1'b0;
      mode_select_high_bit_q <= 1'b0;
      mode_low_bit_q <= 1'b0;
      fast_mode0_or_multiproc_bit_q <= 1'b0;
      receive_enable_q <= 1'b0;
    end else begin
      if (wr_trim_hi) osc_trim_high_q <= w_data_q;
      if (wr_trim_lo) osc_trim_low_bit_q <= w_data_q[0];
      if (wr_t3_ctrl) t3_ctrl_q <= w_data_q;
      if (wr_reload_lo) timer3_reload_low_q <= w_data_q;
      if (wr_reload_hi) timer3_reload_high_q <= w_data_q;
      if (wr_pwr_ctrl) begin
        port0_baud_double_q <= w_data_q[PC_DBL];
        error_flag_access_select_q <= w_data_q[PC_FEA];
      end
      if (wr_ser_ctrl) begin
        // mode bit kept apart from the error flag
        if (!error_flag_access_select_q) mode_select_high_bit_q <= w_data_q[SC_TOP];
        mode_low_bit_q <= w_data_q[SC_SM1];
        fast_mode0_or_multiproc_bit_q <= w_data_q[SC_FAST_MP];
        receive_enable_q <= w_data_q[SC_REN];
      end
    end
  end

  assign oscillator_trim_value = {osc_trim_high_q, osc_trim_low_bit_q};
  assign timer3_reload_value = {timer3_reload_high_q, timer3_reload_low_q};
  assign timer3_uart_control = t3_ctrl_q;

  // Baud generation
  wire ubf_mode_t mode = ubf_mode_t'({mode_select_high_bit_q, mode_low_bit_q});
  wire mode_async = mode != UBF_MODE0;
  wire mode_timer = mode == UBF_MODE1 || mode == UBF_MODE3;
  wire baud_source_select = t3_ctrl_q[T3C_SRC_SEL];
  wire ovf_sel = baud_source_select ? timer3_overflow : timer1_overflow;
  logic half_q;
  logic [3:0] pre_q;
  logic [3:0] p0_div_q;
  logic [3:0] p1_div_q;
  wire [3:0] pre_lim = mode == UBF_MODE0 ?
                       (fast_mode0_or_multiproc_bit_q ? M0_LIM_FAST : M0_LIM_SLOW) :
                       (port0_baud_double_q ? M2_LIM_FAST : M2_LIM_SLOW);
  wire pre_hit = pre_q >= pre_lim;
  // sixteen samples per bit from 16 or 32 overflows
  wire timer_samp = ovf_sel && (port0_baud_double_q || half_q);
  wire samp_tick = mode_timer ? timer_samp : (mode == UBF_MODE2 && pre_hit);
  wire p0_bit = mode == UBF_MODE0 ? pre_hit : (samp_tick && p0_div_q == OVS_LAST);
  // port 1 runs only from Timer3, one bit per 16 overflows
  wire p1_bit = timer3_overflow && p1_div_q == OVS_LAST;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_q <= 1'b0;
      pre_q <= 4'h0;
      p0_div_q <= 4'h0;
      p1_div_q <= 4'h0;
      port0_sample_tick <= 1'b0;
      port0_bit_tick <= 1'b0;
      port1_bit_tick <= 1'b0;
    end else begin
      if (ovf_sel) half_q <= !half_q;
      pre_q <= pre_hit ? 4'h0 : pre_q + 4'h1;
      if (samp_tick) p0_div_q <= p0_div_q + 4'h1;
      if (timer3_overflow) p1_div_q <= p1_div_q + 4'h1;
      port0_sample_tick <= samp_tick;
      port0_bit_tick <= p0_bit;
      port1_bit_tick <= p1_bit;
    end
  end

  // Receiver: the line is a pin, so it passes two flops first
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_prev_q;
  ubf_rx_state_t st_q;
  logic [3:0] cnt_q;
  logic [3:0] bit_q;
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] word_q;
  ubf_stream_if #(.WIDTH(WORD_W)) rx_in ();
  ubf_stream_if #(.WIDTH(WORD_W)) rx_out ();
  wire fall = rx_prev_q && !rx_s2_q;
  wire at_mid = samp_tick && cnt_q == MID_SAMPLE;
  wire at_end = samp_tick && cnt_q == OVS_LAST;
  wire [3:0] nbits = mode == UBF_MODE1 ? BITS_M1 : BITS_M23;
  wire stop_eval = st_q == RX_STOP && at_mid;
  wire ferr_event = stop_eval && !rx_s2_q;
  // Ninth bit: the stop bit in mode 1, the received ninth bit otherwise
  wire ninth = mode == UBF_MODE1 ? rx_s2_q : shift_q[WORD_W-1];
  wire [WORD_W-1:0] word = mode == UBF_MODE1 ? {rx_s2_q, shift_q[WORD_W-1:1]} : shift_q;
  assign rx_in.valid = st_q == RX_PUSH;
  assign rx_in.data = word_q;
  assign rx_out.ready = rx_ready;
  assign rx_valid = rx_out.valid;
  assign rx_data = rx_out.data;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_s1_q <= rx0_pin;
      rx_s2_q <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= RX_IDLE;
      cnt_q <= 4'h0;
      bit_q <= 4'h0;
      shift_q <= '0;
      word_q <= '0;
    end else begin
      if (samp_tick) cnt_q <= cnt_q + 4'h1;
      case (st_q)
        RX_IDLE: begin
          cnt_q <= 4'h0;
          if (fall && receive_enable_q && mode_async) st_q <= RX_START;
        end
        RX_START: begin
          if (at_mid && rx_s2_q) st_q <= RX_IDLE;
          else if (at_end) begin
            st_q <= RX_SHIFT;
            bit_q <= 4'h0;
          end
        end
        RX_SHIFT: begin
          if (at_mid) shift_q <= {rx_s2_q, shift_q[WORD_W-1:1]};
          if (at_end) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == nbits - 4'h1) st_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (stop_eval) begin
            word_q <= word;
            st_q <= (!fast_mode0_or_multiproc_bit_q || ninth) ? RX_PUSH : RX_IDLE;
          end
        end
        RX_PUSH: begin
          // A full buffer holds the receiver here rather than drop the word
          if (rx_in.ready) st_q <= RX_IDLE;
        end
        default: st_q <= RX_IDLE;
      endcase
    end
  end

  ubf_buffer u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_s(rx_in.snk),
    .out_s(rx_out.src)
  );

  // sticky flag, set wins over a software clear
  wire ferr_wr = wr_ser_ctrl && error_flag_access_select_q;
  assign framing_error_flag_d = ferr_event || (ferr_wr ? w_data_q[SC_TOP] : framing_error_flag_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) framing_error_flag_q <= 1'b0;
    else framing_error_flag_q <= framing_error_flag_d;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_src_t1;
    (mode_timer && !baud_source_select && port0_baud_double_q && !timer1_overflow) |=> !port0_sample_tick;
  endproperty
  a_src_t1: assert property (p_src_t1) else $error("port0 tick without timer1 overflow");
  property p_m0_fast;
    disable iff (!aresetn || reg_wr)
    (mode == UBF_MODE0 && fast_mode0_or_multiproc_bit_q && p0_bit) |=> !p0_bit ##1 p0_bit;
  endproperty
  a_m0_fast: assert property (p_m0_fast) else $error("mode0 fast shift rate wrong");
  property p_m2_slow;
    disable iff (!aresetn || reg_wr)
    (mode == UBF_MODE2 && !port0_baud_double_q && samp_tick) |=> (!samp_tick)[*3] ##1 samp_tick;
  endproperty
  a_m2_slow: assert property (p_m2_slow) else $error("mode2 sample rate wrong");
  property p_half;
    (mode_timer && !port0_baud_double_q && ovf_sel && !half_q) |-> !samp_tick;
  endproperty
  a_half: assert property (p_half) else $error("undoubled rate took every overflow");
  property p_p1;
    (timer3_overflow && p1_div_q == OVS_LAST) |=> port1_bit_tick && p1_div_q == 4'h0;
  endproperty
  a_p1: assert property (p_p1) else $error("port1 bit tick off");
  property p_trim;
    wr_trim_hi |=> oscillator_trim_value[8:1] == $past(w_data_q);
  endproperty
  a_trim: assert property (p_trim) else $error("trim write not applied");
  property p_ferr_set;
    ferr_event |=> framing_error_flag_q;
  endproperty
  a_ferr_set: assert property (p_ferr_set) else $error("framing error not flagged");
  property p_ferr_sticky;
    (framing_error_flag_q && !ferr_wr) |=> framing_error_flag_q;
  endproperty
  a_ferr_sticky: assert property (p_ferr_sticky) else $error("framing error lost");
  property p_ferr_read;
    (s_axi_arvalid && s_axi_arready && rd_idx == IDX_SER_CTRL && error_flag_access_select_q)
      |=> s_axi_rdata[SC_TOP] == $past(framing_error_flag_q);
  endproperty
  a_ferr_read: assert property (p_ferr_read) else $error("top bit not error flag");
  property p_mid;
    (st_q == RX_STOP && samp_tick && cnt_q != MID_SAMPLE) |=> st_q == RX_STOP;
  endproperty
  a_mid: assert property (p_mid) else $error("stop left before its midpoint");
  c_ferr: cover property (ferr_event);
  c_push: cover property (rx_in.valid && rx_in.ready);
  c_full: cover property (rx_valid && !rx_ready && !rx_in.ready);
endmodule
`default_nettype wire

// ==== verification/ubf_serial_node.sv ====
`timescale 1ns/1ps
`default_nettype none
module ubf_serial_node (
  input wire logic aclk,
  output logic line
);
  // The line is driven push-pull by the remote node and rests at the mark level
  initial line = 1'b1;

  // Start bit, eight data bits LSB first, then the ninth or stop level
  task automatic send(input logic [7:0] b, input logic stop_bit, input int bit_cyc);
    logic [9:0] f;
    f = {stop_bit, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= f[i];
      repeat (bit_cyc) @(posedge aclk);
    end
    line <= 1'b1;
    // Two idle bit times so the next falling edge is a clean start
    repeat (2 * bit_cyc) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ==== verification/ubf_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module ubf_top_tb_top
  import ubf_pkg::*;
;
  localparam logic [8:0] TRIM_INIT = 9'h100;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic timer1_overflow = 1'b0, timer3_overflow = 1'b0, rx0_pin, rx_ready = 1'b0, rx_valid;
  logic port0_sample_tick, port0_bit_tick, port1_bit_tick;
  logic [8:0] oscillator_trim_value;
  logic [15:0] timer3_reload_value;
  logic [7:0] timer3_uart_control;
  logic [WORD_W-1:0] rx_data;
  int n_errors = 0, comparisons = 0;
  int t1_per = 0, t3_per = 0, t1_cnt = 0, t3_cnt = 0;

  ubf_top #(.TRIM_RESET(TRIM_INIT)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timer1_overflow, .timer3_overflow, .rx0_pin, .port0_sample_tick, .port0_bit_tick, .port1_bit_tick,
    .oscillator_trim_value, .timer3_reload_value, .timer3_uart_control, .rx_data, .rx_valid, .rx_ready);

  ubf_serial_node node (.aclk(aclk), .line(rx0_pin));

  initial begin
    forever #5 aclk = ~aclk;
  end

  // Stand-in timers: one-cycle overflow pulses at a chosen period, zero means stopped
  // period never one
  always @(posedge aclk) begin
    t1_cnt <= (t1_cnt + 1 >= t1_per) ? 0 : t1_cnt + 1;
    t3_cnt <= (t3_cnt + 1 >= t3_per) ? 0 : t3_cnt + 1;
    timer1_overflow <= t1_per != 0 && t1_cnt == 0;
    timer3_overflow <= t3_per != 0 && t3_cnt == 0;
  end

  task automatic wr(input logic [7:0] idx, input logic [7:0] v, input logic [3:0] s, output logic [1:0] r);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wok(input logic [7:0] idx, input logic [7:0] v);
    logic [1:0] r;
    wr(idx, v, 4'hF, r);
    `CHK("bresp", RESP_OKAY, r)
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    `CHK("rdata", e, d & m)
    `CHK("rresp", RESP_OKAY, r)
  endtask

  function automatic logic tk(input int sel);
    return sel == 0 ? port0_bit_tick : (sel == 1 ? port0_sample_tick : port1_bit_tick);
  endfunction

  task automatic gap(input int sel, output int g);
    g = 0;
    do @(posedge aclk); while (tk(sel) !== 1'b1);
    do begin
      @(posedge aclk);
      g++;
    end while (tk(sel) !== 1'b1);
  endtask

  // First gap after a mode change may straddle old and new settings, so judge the second
  task automatic rate(input int sel, input int e);
    int g;
    gap(sel, g);
    gap(sel, g);
    `CHK("tick_gap", e, g)
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    `CHK("trim", TRIM_INIT, oscillator_trim_value)
    rchk(IDX_T3_CTRL, 32'h0, 32'hFFFFFFFF);
    rchk(IDX_TRIM_HI, 32'h80, 32'hFFFFFFFF);
    wr(IDX_TRIM_HI, 8'h11, 4'h0, r);
    `CHK("trim", TRIM_INIT, oscillator_trim_value)
    wok(IDX_TRIM_HI, 8'h78);
    `CHK("trim", 9'h0F0, oscillator_trim_value)
    wok(IDX_TRIM_LO, 8'hFF);
    `CHK("trim", TRIM_INIT - 9'h00F, oscillator_trim_value)
    rchk(IDX_TRIM_LO, 32'h1, 32'hFFFFFF01);
    wok(IDX_RLD_LO, 8'h34);
    wok(IDX_RLD_HI, 8'hFE);
    `CHK("reload", 16'hFE34, timer3_reload_value)
    rchk(IDX_RLD_HI, 32'hFE, 32'hFFFFFFFF);
    wr(8'h10, 8'h55, 4'hF, r);
    `CHK("bresp", RESP_SLVERR, r)
    rd(8'h10, d, r);
    `CHK("rdata", 32'h0, d)
    `CHK("rresp", RESP_SLVERR, r)
  endtask

  task automatic t_rates;
    wok(IDX_PWR_CTRL, 8'h00);
    wok(IDX_SER_CTRL, 8'h10);
    rate(0, 12);
    wok(IDX_SER_CTRL, 8'h30);
    rate(0, 2);
    wok(IDX_SER_CTRL, 8'h90);
    rate(1, 4);
    wok(IDX_PWR_CTRL, 8'h80);
    rate(1, 2);
    t1_per <= 3;
    t3_per <= 5;
    wok(IDX_SER_CTRL, 8'h50);
    rate(1, 3);
    wok(IDX_PWR_CTRL, 8'h00);
    rate(1, 6);
    rate(2, 80);
    wok(IDX_T3_CTRL, 8'h20);
    `CHK("t3_ctrl", 8'h20, timer3_uart_control)
    rate(1, 10);
    wok(IDX_PWR_CTRL, 8'h80);
    rate(1, 5);
    rate(2, 80);
  endtask

  task automatic take(input logic [8:0] e);
    while (rx_valid !== 1'b1) @(posedge aclk);
    `CHK("rx_data", e, rx_data)
    rx_ready <= 1'b1;
    @(posedge aclk);
    rx_ready <= 1'b0;
    @(posedge aclk);
  endtask

  // Receiver stalled through three frames: two fill the buffer, the third waits in the receiver
  task automatic t_rx;
    t1_per <= 4;
    wok(IDX_T3_CTRL, 8'h00);
    wok(IDX_SER_CTRL, 8'h50);
    node.send(8'h3C, 1'b1, 64);
    node.send(8'h5A, 1'b0, 64);
    node.send(8'hC3, 1'b1, 64);
    `CHK("rx_data", 9'h13C, rx_data)
    rchk(IDX_SER_CTRL, 32'h50, 32'hF0);
    wok(IDX_PWR_CTRL, 8'hC0);
    rchk(IDX_SER_CTRL, 32'hD0, 32'hF0);
    take(9'h13C);
    take(9'h05A);
    take(9'h1C3);
    node.send(8'h81, 1'b1, 64);
    take(9'h181);
    rchk(IDX_SER_CTRL, 32'hD0, 32'hF0);
    wok(IDX_SER_CTRL, 8'h50);
    rchk(IDX_SER_CTRL, 32'h50, 32'hF0);
    wok(IDX_PWR_CTRL, 8'h80);
    rchk(IDX_SER_CTRL, 32'h50, 32'hF0);
    // Mode 3 with the multiprocessor bit set: a ninth bit of zero must not load the buffer
    wok(IDX_SER_CTRL, 8'hF0);
    rate(0, 64);
    rchk(IDX_SER_CTRL, 32'hF0, 32'hF0);
    node.send(8'hA5, 1'b0, 64);
    `CHK("rx_valid", 1'b0, rx_valid)
    node.send(8'h96, 1'b1, 64);
    take(9'h196);
    wok(IDX_PWR_CTRL, 8'hC0);
    rchk(IDX_SER_CTRL, 32'h70, 32'hF0);
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_rates();
    t_rx();
    report_and_stop();
  end

  // Whole run needs well under ten thousand cycles
  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    report_and_stop();
  end
endmodule
`undef CHK
`default_nettype wire
